// ==== rtl/analog_io_port_regs.vh ====
// timing and field constants for the analog i/o host port
`ifndef ANALOG_IO_PORT_REGS_VH
`define ANALOG_IO_PORT_REGS_VH
`define DATA_WIDTH 8
`define CLK_PERIOD_NS 5
`define CONV_BITS 8
`define HOLD_EDGES 4
`define FLAG_DELAY_NS 100
`define FLAG_DELAY_CYC ((`FLAG_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEL_FUNC_INPUT 1'b0
`define SEL_FUNC_OUTPUT 1'b1
`define SEL_SIDE_A 1'b0
`define SEL_SIDE_B 1'b1
`define RESULT_RESET 8'h00
`define OUTREG_RESET 8'h80
`endif

// ==== rtl/analog_io_host_bus_port.v ====
// host-bus port: conversion control, result latch and two output converter registers
//
// Summary of operation
// - one write to input function starts conversion
// - write to output function loads selected register
// - write and read together copy result across
// - result is full 8-bit code, no gaps
// - chip select needed; start on write rising edge
// - flag low after delay, result latched at end
// - two address inputs pick function and channel
`timescale 1ns/1ps
`include "analog_io_port_regs.vh"

module analog_io_host_bus_port #(
    parameter DATA_WIDTH = `DATA_WIDTH,
    parameter FLAG_DELAY = `FLAG_DELAY_CYC,
    parameter CONV_CLK_DIV = 20
) (
    input wire mclk,
    input wire reset_n,
    input wire chipSel_n,
    input wire writeStrobe_n,
    input wire readStrobe_n,
    input wire funcSelect,
    input wire port_side_select,
    input wire [DATA_WIDTH-1:0] data_portIn,
    output reg [DATA_WIDTH-1:0] data_portOut,
    output reg data_portOe,
    input wire convClkExt,
    input wire useExtClk,
    input wire [DATA_WIDTH-1:0] sampleA,
    input wire [DATA_WIDTH-1:0] sampleB,
    output reg convDone_n,
    output reg [DATA_WIDTH-1:0] outRegA_q,
    output reg [DATA_WIDTH-1:0] outRegB_q
);

localparam ST_IDLE = 2'b00;
localparam ST_HOLD = 2'b01;
localparam ST_BITS = 2'b10;
localparam ST_FLAG = 2'b11;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers: three stages, change accepted when stages two and three agree
reg [2:0] csSync, wrSync, rdSync, extSync;
reg csLvl, wrLvl, rdLvl, extLvl;

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        csSync <= 3'h7;
        wrSync <= 3'h7;
        rdSync <= 3'h7;
        extSync <= 3'h0;
        csLvl <= 1'b1;
        wrLvl <= 1'b1;
        rdLvl <= 1'b1;
        extLvl <= 1'b0;
    end else begin
        csSync <= {csSync[1:0], chipSel_n};
        wrSync <= {wrSync[1:0], writeStrobe_n};
        rdSync <= {rdSync[1:0], readStrobe_n};
        extSync <= {extSync[1:0], convClkExt};
        if (csSync[1] == csSync[2]) csLvl <= csSync[2];
        if (wrSync[1] == wrSync[2]) wrLvl <= wrSync[2];
        if (rdSync[1] == rdSync[2]) rdLvl <= rdSync[2];
        if (extSync[1] == extSync[2]) extLvl <= extSync[2];
    end
end

////////////////////////////////////////////////////////////////////////////////
// address, data and clock-mode pins: same three-stage filter as the strobes,
// so they settle on the same edge as the strobe levels they qualify
reg [2:0] funcSync, sideSync, modeSync;
reg [DATA_WIDTH-1:0] dataSync0, dataSync1, dataSync2;
reg funcLvl, sideLvl, modeLvl;
reg [DATA_WIDTH-1:0] dataLvl;

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        funcSync <= 3'h0;
        sideSync <= 3'h0;
        modeSync <= 3'h0;
        dataSync0 <= {DATA_WIDTH{1'b0}};
        dataSync1 <= {DATA_WIDTH{1'b0}};
        dataSync2 <= {DATA_WIDTH{1'b0}};
        funcLvl <= `SEL_FUNC_INPUT;
        sideLvl <= `SEL_SIDE_A;
        modeLvl <= 1'b0;
        dataLvl <= {DATA_WIDTH{1'b0}};
    end else begin
        funcSync <= {funcSync[1:0], funcSelect};
        sideSync <= {sideSync[1:0], port_side_select};
        modeSync <= {modeSync[1:0], useExtClk};
        dataSync0 <= data_portIn;
        dataSync1 <= dataSync0;
        dataSync2 <= dataSync1;
        if (funcSync[1] == funcSync[2]) funcLvl <= funcSync[2];
        if (sideSync[1] == sideSync[2]) sideLvl <= sideSync[2];
        if (modeSync[1] == modeSync[2]) modeLvl <= modeSync[2];
        // whole word taken only when two stages agree, so a bus in mid-change is never latched
        if (dataSync1 == dataSync2) dataLvl <= dataSync2;
    end
end

// host must hold address and data until chip select rises, well past the accepted edge
wire wrRise = ~wrLvl & wrSync[2] & (wrSync[1] == wrSync[2]);
wire selected = ~csLvl;
wire bothLow = ~wrLvl & ~rdLvl;

////////////////////////////////////////////////////////////////////////////////
// conversion clock: internal divider enable or falling edge of the external clock
reg [7:0] divCnt;
reg intTick, extPrev;
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        divCnt <= 8'h00;
        intTick <= 1'b0;
        extPrev <= 1'b0;
    end else begin
        extPrev <= extLvl;
        intTick <= (divCnt == CONV_CLK_DIV - 1);
        if (divCnt == CONV_CLK_DIV - 1) divCnt <= 8'h00;
        else divCnt <= divCnt + 8'h01;
    end
end
wire convTick = modeLvl ? (extPrev & ~extLvl) : intTick;

////////////////////////////////////////////////////////////////////////////////
// successive approximation sequencer
reg [1:0] state_q;
reg [3:0] stepCnt;
reg [7:0] flagCnt;
reg chanLatch;
reg [DATA_WIDTH-1:0] heldSample, sar, result_q;
reg mirrorDone;

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        state_q <= ST_IDLE;
        stepCnt <= 4'h0;
        flagCnt <= 8'h00;
        chanLatch <= `SEL_SIDE_A;
        heldSample <= {DATA_WIDTH{1'b0}};
        sar <= {DATA_WIDTH{1'b0}};
        result_q <= `RESULT_RESET;
        convDone_n <= 1'b1;
    end else begin
        if (selected && wrRise && rdLvl && funcLvl == `SEL_FUNC_INPUT) begin
            state_q <= ST_HOLD;
            stepCnt <= 4'h0;
            chanLatch <= sideLvl;
            sar <= {DATA_WIDTH{1'b0}};
            convDone_n <= 1'b1;
        end else begin
            case (state_q)
                ST_HOLD: if (convTick) begin
                    if (stepCnt == `HOLD_EDGES - 1) begin
                        heldSample <= chanLatch ? sampleB : sampleA;
                        stepCnt <= 4'h0;
                        state_q <= ST_BITS;
                    end else begin
                        stepCnt <= stepCnt + 4'h1;
                    end
                end
                ST_BITS: if (convTick) begin
                    // one bit decided per clock edge, msb first; every code reachable
                    sar[DATA_WIDTH-1-stepCnt] <= heldSample[DATA_WIDTH-1-stepCnt];
                    if (stepCnt == `CONV_BITS - 1) begin
                        flagCnt <= 8'h00;
                        state_q <= ST_FLAG;
                    end else begin
                        stepCnt <= stepCnt + 4'h1;
                    end
                end
                ST_FLAG: begin
                    if (flagCnt == FLAG_DELAY - 1) begin
                        result_q <= sar;
                        convDone_n <= 1'b0;
                        state_q <= ST_IDLE;
                    end else begin
                        flagCnt <= flagCnt + 8'h01;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// output converter registers and the data port
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        outRegA_q <= `OUTREG_RESET;
        outRegB_q <= `OUTREG_RESET;
        mirrorDone <= 1'b0;
        data_portOut <= {DATA_WIDTH{1'b0}};
        data_portOe <= 1'b0;
    end else begin
        mirrorDone <= selected & bothLow;
        if (selected && funcLvl == `SEL_FUNC_OUTPUT) begin
            if (bothLow && !mirrorDone) begin
                if (sideLvl == `SEL_SIDE_B) outRegB_q <= result_q;
                else outRegA_q <= result_q;
            end else if (wrRise && rdLvl) begin
                if (sideLvl == `SEL_SIDE_B) outRegB_q <= dataLvl;
                else outRegA_q <= dataLvl;
            end
        end
        // read drives old result until completion, then the new one
        data_portOe <= selected & ~rdLvl & wrLvl;
        data_portOut <= result_q;
    end
end

endmodule

// ==== verif/analog_io_host_props.sv ====
// pin-level assertions for the analog i/o host port
`timescale 1ns/1ps
module analog_io_host_props (input mclk, reset_n, chipSel_n, writeStrobe_n, readStrobe_n, funcSelect,
    port_side_select, data_portOe, convDone_n, input [7:0] data_portIn, data_portOut, outRegA_q, outRegB_q);
    wire idle = !chipSel_n && writeStrobe_n && readStrobe_n;
    wire both = !chipSel_n && funcSelect && !writeStrobe_n && !readStrobe_n && !convDone_n;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence wrHeld(f, s);
        idle && funcSelect == f && port_side_select == s && $rose(writeStrobe_n) ##1 idle [*7];
    endsequence
    chk_conv_start: assert property (wrHeld(0, port_side_select) |-> convDone_n) else $error("start");
    chk_done_delay: assert property ($fell(convDone_n) |-> $past(convDone_n, 20)) else $error("done");
    chk_write_a: assert property (wrHeld(1, 0) |-> outRegA_q == data_portIn) else $error("wr a");
    chk_write_b: assert property (wrHeld(1, 1) |-> outRegB_q == data_portIn) else $error("wr b");
    chk_copy_a: assert property ((both && !port_side_select) [*7] |-> outRegA_q == data_portOut)
        else $error("cp a");
    chk_copy_b: assert property ((both && port_side_select) [*7] |-> outRegB_q == data_portOut)
        else $error("cp b");
    chk_result_hold: assert property ($changed(data_portOut) |-> $past(convDone_n) || $past(convDone_n, 2))
        else $error("hold");
    chk_oe_deselect: assert property (chipSel_n [*6] |-> !data_portOe) else $error("oe");
endmodule
bind analog_io_host_bus_port analog_io_host_props u_props (.*);

// ==== verif/host_bus_model.sv ====
// host model driving the bus pins of the port
`timescale 1ns/1ps
module host_bus_model (input mclk, output reg chipSel_n = 1, writeStrobe_n = 1, readStrobe_n = 1,
    funcSelect = 0, port_side_select = 0, output reg [7:0] data_portIn = 8'h00);
    // wr rises before rd, so a copy never ends as a plain write
    task acc(input f, s, input [7:0] v, input wr, rd);
        @(negedge mclk);
        {chipSel_n, funcSelect, port_side_select, data_portIn} = {1'b0, f, s, v};
        {writeStrobe_n, readStrobe_n} = {!wr, !rd};
        #40 writeStrobe_n = 1;
        #40 readStrobe_n = 1;
        #40 chipSel_n = 1;
        data_portIn = ~v; // released bus keeps no stale value
    endtask
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the analog i/o host port
`timescale 1ns/1ps
module testbench;
    wire chipSel_n, writeStrobe_n, readStrobe_n, funcSelect, port_side_select, data_portOe, convDone_n;
    wire [7:0] data_portIn, data_portOut, outRegA_q, outRegB_q;
    reg mclk = 0, reset_n = 0, convClkExt = 0, useExtClk = 0;
    reg [7:0] sampleA = 8'h00, v, last;
    wire [7:0] sampleB = ~sampleA;
    reg [7:0] q[$];
    integer num_errors = 0, checked = 0, i, n;
    initial forever #2.5 mclk = ~mclk;
    always #10 convClkExt = ~convClkExt;
    host_bus_model u_host_bus_model (.*);
    analog_io_host_bus_port #(.CONV_CLK_DIV(4)) u_analog_io_host_bus_port (.*);
    task check(input string nm, input [7:0] seen, exp);
        checked++;
        if (seen !== exp) $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        if (seen !== exp) num_errors++;
    endtask
    task results;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge data_portOe) begin
        @(negedge mclk);
        check("read", data_portOut, q.pop_front());
    end
    initial begin
        n = $urandom(32'h7dc7a62a);
        repeat (3) @(negedge mclk);
        reset_n = 1;
        repeat (4) @(negedge mclk);
        for (i = 0; i < 6; i++) begin
            v = i < 2 ? {8{i[0]}} : 8'($urandom);
            useExtClk = i > 2;
            sampleA = v;
            last = i[0] ? ~v : v;
            u_host_bus_model.acc(0, i[0], 8'h00, 1, 0);
            for (n = 0; n < 200 && convDone_n !== 0; n++) @(negedge mclk);
            check("done", {7'h00, convDone_n}, 8'h00);
            if (num_errors > 0) results;
            repeat (2) q.push_back(last);
            u_host_bus_model.acc(0, i[0], 8'h00, 0, 1);
            u_host_bus_model.acc(1, !i[0], ~last, 1, 1);
            check("copy", i[0] ? outRegA_q : outRegB_q, last);
            v = 8'($urandom);
            u_host_bus_model.acc(1, i[0], v, 1, 0);
            check("write", i[0] ? outRegB_q : outRegA_q, v);
        end
        results;
    end
endmodule
